// >>> hpp_pkg.sv
// constants and types for the host parallel port dsp-side datapath
//
// Overview of operation
// - six 24-bit registers in x data space, reached by load and store.
// - transmit and receive paths are each double-buffered.
// - only the dsp core reaches these registers; host has no path.
// - upper eight bits of the four control registers read as zero.
// - any reset disables the port, pins become gpio and disconnected.
// - copy host tx bytes to receive word when both flags are clear.
// - that copy sets host tx empty and dsp rx full flags.
// - receive word is read-only; reading it clears rx full.
// - while rx full, receive word is offered to an on-chip dma channel.
// - transmit word is write-only; writing it clears tx empty.
// - move transmit word to host rx bytes when both flags are clear.
// - that move sets host rx full and dsp tx empty flags.
// - status bits after a dsp write become valid two cycles later.
// - control bit 0 with rx full raises receive interrupt request.
// - control bit 1 with tx empty raises transmit interrupt request.
// - control bit 2 with command pending raises command request.
// - command interrupt vector comes from the host command vector register.
// - priority is command, then transmit, then receive.
// - two dsp-written flag bits are shown to the host status.
// - host initialize can also clear the rx full flag.
package hpp_pkg;
    localparam int HPP_DW = 24;
    localparam int HPP_AW = 24;
    // ==========================================================
    // register addresses
    localparam logic [23:0] HPP_ADDR_CTRL = 24'hff_ffc2;
    localparam logic [23:0] HPP_ADDR_STAT = 24'hff_ffc3;
    localparam logic [23:0] HPP_ADDR_PCTL = 24'hff_ffc4;
    localparam logic [23:0] HPP_ADDR_BASE = 24'hff_ffc5;
    localparam logic [23:0] HPP_ADDR_RXW = 24'hff_ffc6;
    localparam logic [23:0] HPP_ADDR_TXW = 24'hff_ffc7;
    // ==========================================================
    // field positions and widths
    localparam int HPP_CTRL_RIE = 0;
    localparam int HPP_CTRL_TIE = 1;
    localparam int HPP_CTRL_CIE = 2;
    localparam int HPP_CTRL_FA = 3;
    localparam int HPP_CTRL_FB = 4;
    localparam int HPP_CTRL_W = 8;
    localparam int HPP_STAT_RDF = 0;
    localparam int HPP_STAT_TDE = 1;
    localparam int HPP_STAT_CP = 2;
    localparam int HPP_STAT_HF0 = 3;
    localparam int HPP_STAT_HF1 = 4;
    localparam int HPP_PCTL_W = 16;
    localparam int HPP_PCTL_EN = 6;
    localparam int HPP_BASE_W = 8;
    localparam int HPP_CREG_W = 16;
    localparam int HPP_VEC_W = 7;
    // ==========================================================
    // reset values
    localparam logic [7:0] HPP_CTRL_RST = 8'h00;
    localparam logic [15:0] HPP_PCTL_RST = 16'h0000;
    localparam logic [7:0] HPP_BASE_RST = 8'h00;
    // status pipeline depth after a dsp write
    localparam int HPP_STAT_DLY = 2;
    // ==========================================================
    // interrupt source encoding
    typedef enum logic [1:0] {
        HPP_IRQ_NONE = 2'b00,
        HPP_IRQ_RX = 2'b01,
        HPP_IRQ_TX = 2'b11,
        HPP_IRQ_CMD = 2'b10
    } hpp_irq_t;
endpackage

// >>> hpp_skid.sv
// two-entry valid/ready buffer for 24-bit words
`timescale 1ns/1ps
`default_nettype none
module hpp_skid #(
    parameter int WIDTH = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != 2'd2);
    assign out_valid = (cnt_reg != 2'd0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            cnt_reg <= 2'd0;
        end else if (flush) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            cnt_reg <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'd1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'd1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule
`default_nettype wire

// >>> hpp_dsp_side.sv
// dsp-side datapath, flags and interrupt requests of the host parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_dsp_side
    import hpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic soft_rst,
    // dsp core x-memory access
    input wire logic [23:0] dsp_addr,
    input wire logic dsp_rd,
    input wire logic dsp_wr,
    input wire logic [23:0] dsp_wdata,
    output logic [23:0] dsp_rdata,
    // on-chip dma channel
    output logic dma_rx_req,
    output logic dma_tx_req,
    // host-side byte registers
    input wire logic [23:0] host_tx_bytes,
    input wire logic host_tx_valid,
    output logic host_tx_taken,
    output logic [23:0] host_rx_bytes,
    output logic host_rx_full_flag,
    input wire logic host_rx_read,
    input wire logic host_init,
    input wire logic command_pending_flag,
    input wire logic [6:0] command_vector_reg,
    input wire logic [1:0] host_flags_in,
    output logic dsp_to_host_flag_a,
    output logic dsp_to_host_flag_b,
    output logic port_enable,
    // interrupt request to the core
    output logic irq_req,
    output logic [1:0] irq_source,
    output logic [6:0] irq_vector
);
    logic [7:0] port_control_reg;
    logic [15:0] pin_control_reg;
    logic [7:0] base_address_reg;
    logic [23:0] dsp_receive_word;
    logic dsp_rx_full_flag;
    logic dsp_tx_empty_flag;
    logic [23:0] host_rx_reg;
    logic host_rx_full_reg;
    logic [HPP_STAT_DLY-1:0] tde_pipe_reg;
    logic [23:0] rdata_next;
    logic rd_rx;
    logic wr_tx;
    logic fill_rx;
    logic tx_in_ready;
    logic tx_out_valid;
    logic [23:0] tx_out_data;
    logic drain_tx;
    logic any_rst;
    hpp_irq_t src_next;

    function automatic logic hit(input logic [23:0] a, input logic [23:0] b);
        return a == b;
    endfunction

    assign any_rst = soft_rst;
    // ==========================================================
    // access decode
    // core-only decode
    assign rd_rx = dsp_rd && hit(dsp_addr, HPP_ADDR_RXW);
    assign wr_tx = dsp_wr && hit(dsp_addr, HPP_ADDR_TXW);

    // ==========================================================
    // control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_control_reg <= HPP_CTRL_RST;
            pin_control_reg <= HPP_PCTL_RST;
            base_address_reg <= HPP_BASE_RST;
        end else if (any_rst) begin
            port_control_reg <= HPP_CTRL_RST;
            pin_control_reg <= HPP_PCTL_RST;
            base_address_reg <= HPP_BASE_RST;
        end else if (dsp_wr) begin
            if (hit(dsp_addr, HPP_ADDR_CTRL)) begin
                port_control_reg <= dsp_wdata[HPP_CTRL_W-1:0];
            end
            if (hit(dsp_addr, HPP_ADDR_PCTL)) begin
                pin_control_reg <= dsp_wdata[HPP_PCTL_W-1:0];
            end
            if (hit(dsp_addr, HPP_ADDR_BASE)) begin
                base_address_reg <= dsp_wdata[HPP_BASE_W-1:0];
            end
        end
    end

    // ==========================================================
    // host-to-dsp receive word
    // copy when host word valid, receive word empty and port enabled
    assign fill_rx = host_tx_valid && !dsp_rx_full_flag && port_enable;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dsp_rx_full_flag <= 1'b0;
            dsp_receive_word <= 24'h00_0000;
            host_tx_taken <= 1'b0;
        end else begin
            host_tx_taken <= fill_rx;
            if (any_rst) begin
                dsp_rx_full_flag <= 1'b0;
            end else if (fill_rx) begin
                dsp_rx_full_flag <= 1'b1;
                dsp_receive_word <= host_tx_bytes;
            end else if (rd_rx || host_init) begin
                dsp_rx_full_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // dsp-to-host transmit path, double-buffered
    // buffer between transmit word and host bytes
    hpp_skid #(
        .WIDTH(HPP_DW)
    ) u_tx_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(any_rst),
        .in_valid(wr_tx),
        .in_ready(tx_in_ready),
        .in_data(dsp_wdata),
        .out_valid(tx_out_valid),
        .out_ready(!host_rx_full_reg && port_enable),
        .out_data(tx_out_data)
    );

    assign drain_tx = tx_out_valid && !host_rx_full_reg && port_enable;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_rx_full_reg <= 1'b0;
            host_rx_reg <= 24'h00_0000;
        end else if (any_rst || host_init) begin
            host_rx_full_reg <= 1'b0;
        end else if (drain_tx) begin
            host_rx_full_reg <= 1'b1;
            host_rx_reg <= tx_out_data;
        end else if (host_rx_read) begin
            host_rx_full_reg <= 1'b0;
        end
    end

    // write clears empty, seen two cycles on
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tde_pipe_reg <= '1;
            dsp_tx_empty_flag <= 1'b1;
        end else if (any_rst) begin
            tde_pipe_reg <= '1;
            dsp_tx_empty_flag <= 1'b1;
        end else begin
            tde_pipe_reg <= {tde_pipe_reg[HPP_STAT_DLY-2:0],
                             tx_in_ready && !wr_tx};
            dsp_tx_empty_flag <= tde_pipe_reg[HPP_STAT_DLY-2] && tx_in_ready;
        end
    end

    // ==========================================================
    // read data
    always_comb begin
        rdata_next = 24'h00_0000;
        unique case (dsp_addr)
            HPP_ADDR_CTRL: rdata_next = {16'h0000, port_control_reg};
            HPP_ADDR_STAT: begin
                rdata_next[HPP_STAT_RDF] = dsp_rx_full_flag;
                rdata_next[HPP_STAT_TDE] = dsp_tx_empty_flag;
                rdata_next[HPP_STAT_CP] = command_pending_flag;
                rdata_next[HPP_STAT_HF0] = host_flags_in[0];
                rdata_next[HPP_STAT_HF1] = host_flags_in[1];
            end
            HPP_ADDR_PCTL: rdata_next = {8'h00, pin_control_reg};
            HPP_ADDR_BASE: rdata_next = {16'h0000, base_address_reg};
            HPP_ADDR_RXW: rdata_next = dsp_receive_word;
            default: rdata_next = 24'h00_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dsp_rdata <= 24'h00_0000;
        end else if (dsp_rd) begin
            dsp_rdata <= rdata_next;
        end
    end

    // ==========================================================
    // interrupt priority and outputs
    always_comb begin
        if (port_control_reg[HPP_CTRL_CIE] && command_pending_flag) begin
            src_next = HPP_IRQ_CMD;
        end else if (port_control_reg[HPP_CTRL_TIE] && dsp_tx_empty_flag) begin
            src_next = HPP_IRQ_TX;
        end else if (port_control_reg[HPP_CTRL_RIE] && dsp_rx_full_flag) begin
            src_next = HPP_IRQ_RX;
        end else begin
            src_next = HPP_IRQ_NONE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_req <= 1'b0;
            irq_source <= 2'b00;
            irq_vector <= 7'h00;
            dma_rx_req <= 1'b0;
            dma_tx_req <= 1'b0;
            dsp_to_host_flag_a <= 1'b0;
            dsp_to_host_flag_b <= 1'b0;
            port_enable <= 1'b0;
        end else begin
            irq_req <= (src_next != HPP_IRQ_NONE) && !any_rst;
            irq_source <= any_rst ? HPP_IRQ_NONE : src_next;
            irq_vector <= command_vector_reg;
            dma_rx_req <= dsp_rx_full_flag && !fill_rx && !rd_rx;
            dma_tx_req <= dsp_tx_empty_flag;
            dsp_to_host_flag_a <= port_control_reg[HPP_CTRL_FA];
            dsp_to_host_flag_b <= port_control_reg[HPP_CTRL_FB];
            port_enable <= pin_control_reg[HPP_PCTL_EN] && !any_rst;
        end
    end

    assign host_rx_bytes = host_rx_reg;
    assign host_rx_full_flag = host_rx_full_reg;
endmodule
`default_nettype wire

// >>> hpp_dsp_side_properties.sv
// concurrent checks on the ports of the dsp-side host port datapath
`timescale 1ns/1ps
`default_nettype none
module hpp_dsp_side_properties
    import hpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic [23:0] dsp_addr,
    input wire logic dsp_rd,
    input wire logic dsp_wr,
    input wire logic [23:0] dsp_rdata,
    input wire logic dma_rx_req,
    input wire logic dma_tx_req,
    input wire logic host_tx_valid,
    input wire logic host_tx_taken,
    input wire logic host_rx_full_flag,
    input wire logic command_pending_flag,
    input wire logic [6:0] command_vector_reg,
    input wire logic port_enable,
    input wire logic irq_req,
    input wire logic [1:0] irq_source,
    input wire logic [6:0] irq_vector
);
    // ==========================================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_req_source: assert property (irq_req == (irq_source != HPP_IRQ_NONE))
        else $error("irq request and source disagree");
    a_rx_cause: assert property (irq_source == HPP_IRQ_RX
        && !($past(dsp_rd) && $past(dsp_addr) == HPP_ADDR_RXW) |-> dma_rx_req)
        else $error("receive irq without full word");
    a_tx_cause: assert property (irq_source == HPP_IRQ_TX |-> dma_tx_req)
        else $error("transmit irq without empty flag");
    a_cmd_vector: assert property (irq_source == HPP_IRQ_CMD |->
        $past(command_pending_flag) && irq_vector == $past(command_vector_reg))
        else $error("command irq cause or vector wrong");
    a_taken_full: assert property (host_tx_taken
        && !(dsp_rd && dsp_addr == HPP_ADDR_RXW) |=> dma_rx_req)
        else $error("copy did not set receive full");
    a_read_clears: assert property (dsp_rd && dsp_addr == HPP_ADDR_RXW
        && !host_tx_valid && !host_tx_taken |-> ##[1:2] !dma_rx_req)
        else $error("receive read left full flag");
    a_write_busy: assert property (dsp_wr && dsp_addr == HPP_ADDR_TXW
        && host_rx_full_flag && port_enable ##1 !soft_rst |-> ##2 !dma_tx_req)
        else $error("transmit write left empty flag");
    a_move_enabled: assert property ($rose(host_rx_full_flag) |-> $past(port_enable))
        else $error("word moved while port disabled");
    a_soft_off: assert property (soft_rst |=> !port_enable)
        else $error("soft reset left port enabled");
    a_rdata_hold: assert property (!$past(dsp_rd) |-> $stable(dsp_rdata))
        else $error("read data changed without read");
    c_cmd: cover property (irq_source == HPP_IRQ_CMD);
    c_copy: cover property (host_tx_taken);
    c_move: cover property ($rose(host_rx_full_flag));
endmodule
bind hpp_dsp_side hpp_dsp_side_properties chk_u (.ref_clk, .rst, .soft_rst, .dsp_addr,
    .dsp_rd, .dsp_wr, .dsp_rdata, .dma_rx_req, .dma_tx_req, .host_tx_valid, .host_tx_taken,
    .host_rx_full_flag, .command_pending_flag, .command_vector_reg, .port_enable,
    .irq_req, .irq_source, .irq_vector);
`default_nettype wire

// >>> hpp_host_model.sv
// behavioural host processor on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [23:0] send_word,
    input wire logic send_go,
    input wire logic read_en,
    input wire logic host_tx_taken,
    input wire logic [23:0] host_rx_bytes,
    input wire logic host_rx_full_flag,
    output logic [23:0] host_tx_bytes,
    output logic host_tx_valid,
    output logic host_rx_read,
    output logic [23:0] got_word,
    output logic [7:0] got_cnt
);
    // ==========================================================
    // transmit bytes, released bus shows the inverse
    // offer until taken
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_tx_valid <= 1'b0;
            host_tx_bytes <= 24'h5a_5a5a;
        end else if (send_go) begin
            host_tx_valid <= 1'b1;
            host_tx_bytes <= send_word;
        end else if (host_tx_taken) begin
            host_tx_valid <= 1'b0;
            host_tx_bytes <= ~host_tx_bytes;
        end
    end
    // ==========================================================
    // receive bytes, read_en low stalls the host
    // one read per full word
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_rx_read <= 1'b0;
            got_word <= 24'h00_0000;
            got_cnt <= 8'h00;
        end else begin
            host_rx_read <= read_en && host_rx_full_flag && !host_rx_read;
            if (read_en && host_rx_full_flag && !host_rx_read) begin
                got_word <= host_rx_bytes;
                got_cnt <= got_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test_host_port_dsp_side_datapath.sv
// self-checking bench for the dsp-side host port datapath
`timescale 1ns/1ps
`default_nettype none
module test_host_port_dsp_side_datapath
    import hpp_pkg::*;
;
    logic ref_clk, rst, soft_rst, dsp_rd, dsp_wr, host_tx_valid, host_tx_taken;
    logic host_rx_full_flag, host_rx_read, host_init, command_pending_flag;
    logic dsp_to_host_flag_a, dsp_to_host_flag_b, port_enable, irq_req;
    logic dma_rx_req, dma_tx_req, send_go, read_en;
    logic [23:0] dsp_addr, dsp_wdata, dsp_rdata, host_tx_bytes, host_rx_bytes, send_word;
    logic [23:0] got_word;
    logic [7:0] got_cnt;
    logic [6:0] command_vector_reg, irq_vector;
    logic [1:0] host_flags_in, irq_source;
    logic [23:0] words [0:3];
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    hpp_dsp_side dut_u (.ref_clk, .rst, .soft_rst, .dsp_addr, .dsp_rd, .dsp_wr, .dsp_wdata,
        .dsp_rdata, .dma_rx_req, .dma_tx_req, .host_tx_bytes, .host_tx_valid, .host_tx_taken,
        .host_rx_bytes, .host_rx_full_flag, .host_rx_read, .host_init, .command_pending_flag,
        .command_vector_reg, .host_flags_in, .dsp_to_host_flag_a, .dsp_to_host_flag_b,
        .port_enable, .irq_req, .irq_source, .irq_vector);
    hpp_host_model host_u (.ref_clk, .rst, .send_word, .send_go, .read_en, .host_tx_taken,
        .host_rx_bytes, .host_rx_full_flag, .host_tx_bytes, .host_tx_valid, .host_rx_read,
        .got_word, .got_cnt);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // tasks
    task automatic print_verdict();
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [23:0] a, input logic [23:0] d);
        dsp_addr = a;
        dsp_wdata = d;
        dsp_wr = 1'b1;
        cyc(1);
        dsp_wr = 1'b0;
        // idle edge so a following call never re-raises the strobe in the same step
        cyc(1);
    endtask
    task automatic rdchk(input logic [23:0] a, input logic [23:0] e, input string n);
        dsp_addr = a;
        dsp_rd = 1'b1;
        cyc(1);
        dsp_rd = 1'b0;
        chk(n, dsp_rdata, e);
        cyc(1);
    endtask
    task automatic send(input logic [23:0] w);
        send_word = w;
        send_go = 1'b1;
        cyc(1);
        send_go = 1'b0;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {soft_rst, dsp_rd, dsp_wr, host_init, command_pending_flag, send_go, read_en} = '0;
        dsp_addr = 24'h00_0000;
        dsp_wdata = 24'h00_0000;
        send_word = 24'h00_0000;
        command_vector_reg = 7'h2b;
        host_flags_in = 2'b11;
        words = '{24'h12_3456, 24'hab_cdef, 24'h80_0001, 24'h7f_fffe};
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(1);
        chk("tx empty", 24'(dma_tx_req), 24'h00_0001);
        chk("rx full", 24'(dma_rx_req), 24'h00_0000);
        rdchk(HPP_ADDR_CTRL, 24'h00_0000, "control");
        rdchk(HPP_ADDR_STAT, 24'h00_001a, "status");
        send(words[0]);
        cyc(4);
        chk("copy while off", 24'(dma_rx_req), 24'h00_0000);
        wr(HPP_ADDR_PCTL, 24'h00_0040);
        cyc(3);
        chk("port enable", 24'(port_enable), 24'h00_0001);
        chk("host tx valid", 24'(host_tx_valid), 24'h00_0000);
        rdchk(HPP_ADDR_STAT, 24'h00_001b, "status full");
        send(words[1]);
        cyc(4);
        chk("held while full", 24'(host_tx_valid), 24'h00_0001);
        rdchk(HPP_ADDR_RXW, words[0], "receive word");
        cyc(3);
        rdchk(HPP_ADDR_RXW, words[1], "receive word 2");
        cyc(2);
        chk("rx cleared", 24'(dma_rx_req), 24'h00_0000);
        wr(HPP_ADDR_CTRL, 24'hff_ff18);
        rdchk(HPP_ADDR_CTRL, 24'h00_0018, "control bits");
        chk("flags", 24'({dsp_to_host_flag_b, dsp_to_host_flag_a}), 24'h00_0003);
        // fourth write overruns a full buffer and is dropped
        for (int i = 0; i < 4; i++) wr(HPP_ADDR_TXW, words[i]);
        cyc(2);
        chk("host rx full", 24'(host_rx_full_flag), 24'h00_0001);
        chk("tx busy", 24'(dma_tx_req), 24'h00_0000);
        read_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 50 && got_cnt != 8'(i + 1); k++) cyc(1);
            chk("host word", got_word, words[i]);
        end
        cyc(6);
        chk("host count", 24'(got_cnt), 24'h00_0003);
        chk("tx empty again", 24'(dma_tx_req), 24'h00_0001);
        send(words[2]);
        command_pending_flag = 1'b1;
        wr(HPP_ADDR_CTRL, 24'h00_0007);
        cyc(3);
        chk("cmd source", 24'(irq_source), 24'(HPP_IRQ_CMD));
        chk("cmd vector", 24'(irq_vector), 24'h00_002b);
        command_pending_flag = 1'b0;
        cyc(3);
        chk("tx source", 24'(irq_source), 24'(HPP_IRQ_TX));
        wr(HPP_ADDR_CTRL, 24'h00_0001);
        cyc(3);
        chk("rx source", 24'(irq_source), 24'(HPP_IRQ_RX));
        host_init = 1'b1;
        cyc(1);
        host_init = 1'b0;
        cyc(3);
        chk("init clears rx", 24'(dma_rx_req), 24'h00_0000);
        chk("no irq", 24'(irq_req), 24'h00_0000);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        cyc(2);
        chk("soft disable", 24'(port_enable), 24'h00_0000);
        rdchk(HPP_ADDR_CTRL, 24'h00_0000, "control soft");
        rdchk(24'hff_ffc8, 24'h00_0000, "unmapped");
        wr(HPP_ADDR_BASE, 24'hff_ffa5);
        rdchk(HPP_ADDR_BASE, 24'h00_00a5, "base address");
        wr(HPP_ADDR_PCTL, 24'hff_ff40);
        rdchk(HPP_ADDR_PCTL, 24'h00_ff40, "pin control");
        print_verdict();
    end
endmodule
`default_nettype wire
